// file: pdw_pkg.sv
// Constants, register map and state codes for the power-down and wake block.
// Assumes one 200 MHz system clock and a 16-bit management register port.
package pdw_pkg;

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	localparam int AW = 4;
	localparam int DW = 16;
	localparam logic [AW-1:0] REG_CTRL = 4'h0;
	localparam logic [AW-1:0] REG_STATUS = 4'h1;
	localparam logic [AW-1:0] REG_ENERGY_DETECT_POWER_DOWN_CFG = 4'h2;
	localparam logic [AW-1:0] REG_IRQ_MASK = 4'h3;
	localparam logic [AW-1:0] REG_IRQ_FLAGS = 4'h4;
	localparam logic [AW-1:0] REG_WAKE_CTRL = 4'h5;
	localparam logic [AW-1:0] REG_ADDR_LOW = 4'h6;
	localparam logic [AW-1:0] REG_ADDR_MID = 4'h7;
	localparam logic [AW-1:0] REG_ADDR_HIGH = 4'h8;
	localparam logic [AW-1:0] REG_MISC_CFG = 4'h9;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_PD = 0;
	localparam int CTRL_ENERGY_DETECT_POWER_DOWN = 1;
	localparam int ST_ENERGY = 0;
	localparam int ST_PD = 1;
	localparam int ST_SLEEP = 2;
	localparam int ST_RESET = 3;
	localparam int CFG_TX_EN = 0;
	localparam int CFG_TX_SEL = 1;
	localparam int CFG_SINGLE = 3;
	localparam int CFG_RX_SEL = 4;
	localparam int IRQ_ENERGY = 7;
	localparam int IRQ_WOL = 8;
	localparam int WK_EN = 0;
	localparam int WK_STAT = 4;
	localparam int WK_SELF_CLR = 8;
	localparam int WK_RXD2_SEL = 9;
	localparam int WK_FIRST_INDICATOR_PIN_SEL = 10;
	localparam int WK_SECOND_INDICATOR_PIN_SEL = 12;
	localparam int WK_CONFIGURED = 14;
	localparam int SRC_DEST = 0;
	localparam logic [1:0] PIN_IRQ = 2'h1;
	localparam logic [1:0] PIN_WAKE = 2'h2;
	localparam logic [1:0] PIN_ACT = 2'h3;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [DW-1:0] RST_ZERO = 16'h0000;
	localparam logic [DW-1:0] RST_MISC = 16'h0001;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS = 5;
	localparam int SC_UNIT_NS = 1000;
	localparam int SC_UNIT_CYC = (SC_UNIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int PU_RESET_NS = 10000;
	localparam int PU_RESET_CYC = (PU_RESET_NS + CLK_NS - 1) / CLK_NS;
	localparam int TX_UNIT_MS = 256;
	localparam int TX_UNIT_CYC = TX_UNIT_MS * 1000000 / CLK_NS;
	localparam int RX_UNIT_MS = 20;
	localparam int RX_UNIT_CYC = RX_UNIT_MS * 1000000 / CLK_NS;

	typedef enum logic [2:0] {
		ENERGY_DETECT_POWER_DOWN_RUN = 3'b001,
		ENERGY_DETECT_POWER_DOWN_SLEEP = 3'b010,
		ENERGY_DETECT_POWER_DOWN_ARMED = 3'b100
	} energy_detect_power_down_state_e;

endpackage

// file: pdw_core.sv
// Power-down control, energy-detect power-down and wake-event logic.
// Assumes frame matching results arrive from receive logic on clk_sys.
//
// Summary of operation
// - General power-down bit set keeps transceiver powered down.
// - Clearing power-down powers up and runs an automatic reset.
// - Energy-detect power-down works only while its enable bit is set.
// - Asleep without line energy: power down, transmit nothing but enabled link pulses.
// - Line energy wakes, restores state, sets energy flag; interrupt if unmasked.
// - First one or two packets after waking may be lost.
// - Asleep, link pulses sent only when enabled, at selected interval.
// - Single-pulse wake on one pulse, else two within selected window.
// - Each of four wake sources has its own enable bit.
// - Unmasked wake event holds interrupt low until software clears it.
// - Indicator pin select 10b routes wake output to that pin.
// - Wake output on data pin only if selected and reduced mode.
// - Wake output held until software clears wake status bits 7:4.
// - Self-clear ends wake output after programmed duration.
// - Wake event sets the received bit of its source.
// - Wake registers and configured flag survive software reset.
// - Destination match needs equal 48-bit address and good frame.
// - Destination match: interrupt if unmasked, source flag 8, received bit.
module pdw_core
	import pdw_pkg::*;
#(
	parameter int TX_UNIT = TX_UNIT_CYC,
	parameter int RX_UNIT = RX_UNIT_CYC
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic soft_rst,
	input wire logic [pdw_pkg::AW-1:0] reg_addr,
	input wire logic [pdw_pkg::DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pdw_pkg::DW-1:0] reg_rdata,
	input wire logic line_energy_pin,
	input wire logic nlp_rx_pin,
	input wire logic frame_done,
	input wire logic frame_good,
	input wire logic [47:0] frame_dest,
	input wire logic frame_bcast,
	input wire logic frame_magic,
	input wire logic frame_pattern,
	input wire logic link_act_led,
	input wire logic link_speed_led,
	input wire logic rxd2_data,
	input wire logic reduced_if_strap,
	input wire logic regulator_off_strap,
	input wire logic irq_pin_select_strap,
	output logic xcvr_power_down,
	output logic xcvr_reset,
	output logic tx_nlp_pulse,
	output logic line_energy_present,
	output logic interrupt_out_n,
	output logic wake_event_out_n,
	output logic first_indicator_pin,
	output logic second_indicator_pin,
	output logic rxd2_pin
);
	import pdw_pkg::*;

	function automatic logic [31:0] interval(input logic [1:0] sel,
		input int unit);
		interval = 32'(unit) * (32'(sel) + 32'h1);
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [4:0] s1, s2, s3, filt;
	logic [2:0] strap_cnt;
	logic reduced_if, first_indicator_pin_low, second_indicator_pin_low;
	logic nlp_prev;
	logic energy_prev;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s1 <= 5'h00;
			s2 <= 5'h00;
			s3 <= 5'h00;
			filt <= 5'h00;
		end else begin
			s1 <= {irq_pin_select_strap, regulator_off_strap,
				reduced_if_strap, nlp_rx_pin, line_energy_pin};
			s2 <= s1;
			s3 <= s2;
			filt <= (s2 & s3) | (filt & (s2 ^ s3));
		end
	end

	// Straps are taken once the filter has settled after reset release.
	// The filter first carries a strap at the fourth edge, so capture
	// runs to the fifth; earlier captures would only see reset zeros.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			strap_cnt <= 3'h0;
			reduced_if <= 1'b0;
			first_indicator_pin_low <= 1'b0;
			second_indicator_pin_low <= 1'b0;
		end else if (strap_cnt != 3'h5) begin
			strap_cnt <= strap_cnt + 3'h1;
			reduced_if <= filt[2];
			first_indicator_pin_low <= filt[3];
			second_indicator_pin_low <= filt[4];
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			nlp_prev <= 1'b0;
			energy_prev <= 1'b0;
		end else begin
			nlp_prev <= filt[1];
			energy_prev <= filt[0];
		end
	end

	logic nlp_seen, energy_rise;
	assign nlp_seen = filt[1] && !nlp_prev;
	assign energy_rise = filt[0] && !energy_prev;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [DW-1:0] ctrl, energy_detect_power_down_cfg, irq_mask, irq_flags;
	logic [DW-1:0] wake_ctrl, addr_low, addr_mid, addr_high, misc_cfg;
	logic wr_ctrl, wr_cfg, wr_mask, wr_flags, wr_wake;
	logic [3:0] wake_src;
	logic wake_evt, energy_evt;
	logic [DW-1:0] next_irq_flags;
	logic [3:0] next_wake_stat;

	assign wr_ctrl = reg_wr && reg_addr == REG_CTRL;
	assign wr_cfg = reg_wr && reg_addr == REG_ENERGY_DETECT_POWER_DOWN_CFG;
	assign wr_mask = reg_wr && reg_addr == REG_IRQ_MASK;
	assign wr_flags = reg_wr && reg_addr == REG_IRQ_FLAGS;
	assign wr_wake = reg_wr && reg_addr == REG_WAKE_CTRL;

	// Ordinary control is cleared by software reset
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ctrl <= RST_ZERO;
			energy_detect_power_down_cfg <= RST_ZERO;
			irq_mask <= RST_ZERO;
		end else if (soft_rst) begin
			ctrl <= RST_ZERO;
			energy_detect_power_down_cfg <= RST_ZERO;
			irq_mask <= RST_ZERO;
		end else begin
			if (wr_ctrl)
				ctrl <= reg_wdata;
			if (wr_cfg)
				energy_detect_power_down_cfg <= reg_wdata;
			if (wr_mask)
				irq_mask <= reg_wdata;
		end
	end

	// Source flags: write one to clear, a new event wins over the clear
	always_comb begin
		next_irq_flags = irq_flags;
		if (wr_flags)
			next_irq_flags = irq_flags & ~reg_wdata;
		if (energy_evt)
			next_irq_flags[IRQ_ENERGY] = 1'b1;
		if (wake_evt)
			next_irq_flags[IRQ_WOL] = 1'b1;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			irq_flags <= RST_ZERO;
		else if (soft_rst)
			irq_flags <= RST_ZERO;
		else
			irq_flags <= next_irq_flags;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			interrupt_out_n <= 1'b1;
		else
			interrupt_out_n <= ~|(irq_flags & irq_mask);
	end

	// Wake registers ignore software reset so the configured flag survives
	always_comb begin
		next_wake_stat = wake_ctrl[WK_STAT+:4];
		if (wr_wake)
			next_wake_stat = next_wake_stat & ~reg_wdata[WK_STAT+:4];
		next_wake_stat = next_wake_stat | wake_src;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wake_ctrl <= RST_ZERO;
			addr_low <= RST_ZERO;
			addr_mid <= RST_ZERO;
			addr_high <= RST_ZERO;
			misc_cfg <= RST_MISC;
		end else begin
			if (wr_wake) begin
				wake_ctrl <= reg_wdata;
			end
			wake_ctrl[WK_STAT+:4] <= next_wake_stat;
			if (reg_wr && reg_addr == REG_ADDR_LOW)
				addr_low <= reg_wdata;
			if (reg_wr && reg_addr == REG_ADDR_MID)
				addr_mid <= reg_wdata;
			if (reg_wr && reg_addr == REG_ADDR_HIGH)
				addr_high <= reg_wdata;
			if (reg_wr && reg_addr == REG_MISC_CFG)
				misc_cfg <= reg_wdata;
		end
	end

	// ----------------------------------------
	// Wake sources
	// ----------------------------------------
	logic frame_ok;
	assign frame_ok = frame_done && frame_good;
	always_comb begin
		wake_src[SRC_DEST] = frame_ok && frame_dest ==
			{addr_high, addr_mid, addr_low};
		wake_src[1] = frame_ok && frame_bcast;
		wake_src[2] = frame_ok && frame_magic;
		wake_src[3] = frame_ok && frame_pattern;
		wake_src = wake_src & wake_ctrl[WK_EN+:4];
	end
	assign wake_evt = |wake_src;

	// ----------------------------------------
	// Wake event output
	// ----------------------------------------
	logic [31:0] sc_cnt;
	logic sc_expire;
	assign sc_expire = wake_ctrl[WK_SELF_CLR] && sc_cnt == 32'h1;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			sc_cnt <= 32'h0;
		else if (wake_evt)
			sc_cnt <= 32'(misc_cfg) * 32'(SC_UNIT_CYC) + 32'h1;
		else if (sc_cnt != 32'h0)
			sc_cnt <= sc_cnt - 32'h1;
	end

	// Held while any received bit stands; self-clear may end it earlier
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			wake_event_out_n <= 1'b1;
		else if (wake_evt)
			wake_event_out_n <= 1'b0;
		else if (sc_expire || next_wake_stat == 4'h0)
			wake_event_out_n <= 1'b1;
	end

	// ----------------------------------------
	// Pin functions
	// ----------------------------------------
	function automatic logic pin_mux(input logic [1:0] sel,
		input logic led, input logic low);
		case (sel)
			PIN_IRQ: pin_mux = interrupt_out_n;
			PIN_WAKE: pin_mux = wake_event_out_n;
			PIN_ACT: pin_mux = link_act_led ^ low;
			default: pin_mux = led ^ low;
		endcase
	endfunction

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			first_indicator_pin <= 1'b0;
			second_indicator_pin <= 1'b0;
			rxd2_pin <= 1'b0;
		end else begin
			first_indicator_pin <= pin_mux(wake_ctrl[WK_FIRST_INDICATOR_PIN_SEL+:2],
				link_act_led, first_indicator_pin_low);
			second_indicator_pin <= pin_mux(wake_ctrl[WK_SECOND_INDICATOR_PIN_SEL+:2],
				link_speed_led, second_indicator_pin_low);
			rxd2_pin <= (wake_ctrl[WK_RXD2_SEL] && reduced_if) ?
				wake_event_out_n : rxd2_data;
		end
	end

	// ----------------------------------------
	// Power control
	// ----------------------------------------
	energy_detect_power_down_state_e state;
	logic [31:0] tx_cnt, rx_cnt, pu_cnt;
	logic pd_prev;
	logic energy_detect_power_down_on;
	assign energy_detect_power_down_on = ctrl[CTRL_ENERGY_DETECT_POWER_DOWN];

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= ENERGY_DETECT_POWER_DOWN_RUN;
			rx_cnt <= 32'h0;
		end else begin
			case (state)
				ENERGY_DETECT_POWER_DOWN_RUN:
					if (energy_detect_power_down_on && !filt[0])
						state <= ENERGY_DETECT_POWER_DOWN_SLEEP;
				ENERGY_DETECT_POWER_DOWN_SLEEP:
					if (!energy_detect_power_down_on || filt[0])
						state <= ENERGY_DETECT_POWER_DOWN_RUN;
					else if (nlp_seen && energy_detect_power_down_cfg[CFG_SINGLE])
						state <= ENERGY_DETECT_POWER_DOWN_RUN;
					else if (nlp_seen) begin
						state <= ENERGY_DETECT_POWER_DOWN_ARMED;
						rx_cnt <= interval(energy_detect_power_down_cfg[CFG_RX_SEL+:2], RX_UNIT);
					end
				ENERGY_DETECT_POWER_DOWN_ARMED: begin
					rx_cnt <= rx_cnt - 32'h1;
					if (!energy_detect_power_down_on || filt[0] || nlp_seen)
						state <= ENERGY_DETECT_POWER_DOWN_RUN;
					else if (rx_cnt == 32'h0)
						state <= ENERGY_DETECT_POWER_DOWN_SLEEP;
				end
				default: state <= ENERGY_DETECT_POWER_DOWN_RUN;
			endcase
		end
	end

	// Waking from sleep restores the pre-sleep state; packets may be lost
	assign energy_evt = energy_rise ||
		(state != ENERGY_DETECT_POWER_DOWN_RUN && energy_detect_power_down_on && nlp_seen &&
		(state == ENERGY_DETECT_POWER_DOWN_ARMED || energy_detect_power_down_cfg[CFG_SINGLE]));

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tx_cnt <= 32'h0;
			tx_nlp_pulse <= 1'b0;
		end else if (state == ENERGY_DETECT_POWER_DOWN_RUN || !energy_detect_power_down_cfg[CFG_TX_EN]) begin
			tx_cnt <= interval(energy_detect_power_down_cfg[CFG_TX_SEL+:2], TX_UNIT);
			tx_nlp_pulse <= 1'b0;
		end else if (tx_cnt == 32'h0) begin
			tx_cnt <= interval(energy_detect_power_down_cfg[CFG_TX_SEL+:2], TX_UNIT);
			tx_nlp_pulse <= 1'b1;
		end else begin
			tx_cnt <= tx_cnt - 32'h1;
			tx_nlp_pulse <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pd_prev <= 1'b0;
			pu_cnt <= 32'h0;
		end else begin
			pd_prev <= ctrl[CTRL_PD];
			if (pd_prev && !ctrl[CTRL_PD])
				pu_cnt <= 32'(PU_RESET_CYC);
			else if (pu_cnt != 32'h0)
				pu_cnt <= pu_cnt - 32'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			xcvr_power_down <= 1'b0;
			xcvr_reset <= 1'b0;
			line_energy_present <= 1'b0;
		end else begin
			xcvr_power_down <= ctrl[CTRL_PD] || state != ENERGY_DETECT_POWER_DOWN_RUN;
			xcvr_reset <= pu_cnt != 32'h0;
			line_energy_present <= filt[0];
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			reg_rdata <= RST_ZERO;
		else if (!reg_rd)
			reg_rdata <= RST_ZERO;
		else
			case (reg_addr)
				REG_CTRL: reg_rdata <= ctrl;
				REG_STATUS: reg_rdata <= {12'h000, xcvr_reset,
					state != ENERGY_DETECT_POWER_DOWN_RUN, xcvr_power_down, line_energy_present};
				REG_ENERGY_DETECT_POWER_DOWN_CFG: reg_rdata <= energy_detect_power_down_cfg;
				REG_IRQ_MASK: reg_rdata <= irq_mask;
				REG_IRQ_FLAGS: reg_rdata <= irq_flags;
				REG_WAKE_CTRL: reg_rdata <= wake_ctrl;
				REG_ADDR_LOW: reg_rdata <= addr_low;
				REG_ADDR_MID: reg_rdata <= addr_mid;
				REG_ADDR_HIGH: reg_rdata <= addr_high;
				REG_MISC_CFG: reg_rdata <= misc_cfg;
				default: reg_rdata <= RST_ZERO;
			endcase
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	sequence wol_unmasked;
		wake_evt && irq_mask[IRQ_WOL] && !soft_rst && !wr_mask;
	endsequence
	sequence int_low_two;
		##2 !interrupt_out_n;
	endsequence

	a_pd_holds_off:
	assert property (ctrl[CTRL_PD] |=> xcvr_power_down)
		else $error("power-down bit set but transceiver powered");
	a_pd_release_reset:
	assert property ($fell(ctrl[CTRL_PD]) |=> ##1 xcvr_reset [*3])
		else $error("no reset after power-down release");
	a_energy_detect_power_down_disabled:
	assert property (!energy_detect_power_down_on |=> state == ENERGY_DETECT_POWER_DOWN_RUN)
		else $error("sleeping with energy-detect disabled");
	a_sleep_no_tx:
	assert property (!energy_detect_power_down_cfg[CFG_TX_EN] && !$past(energy_detect_power_down_cfg[CFG_TX_EN])
		|-> !tx_nlp_pulse)
		else $error("pulse sent while transmit disabled");
	a_energy_wakes:
	assert property (state == ENERGY_DETECT_POWER_DOWN_SLEEP && filt[0] |=> state == ENERGY_DETECT_POWER_DOWN_RUN)
		else $error("line energy did not wake");
	a_single_wake:
	assert property (state == ENERGY_DETECT_POWER_DOWN_SLEEP && nlp_seen && energy_detect_power_down_cfg[CFG_SINGLE]
		|=> state == ENERGY_DETECT_POWER_DOWN_RUN)
		else $error("single pulse did not wake");
	a_wol_irq_low:
	assert property (wol_unmasked |-> int_low_two)
		else $error("wake event did not pull interrupt low");
	a_dest_status:
	assert property (wake_src[SRC_DEST] |=> wake_ctrl[WK_STAT+SRC_DEST]
		&& irq_flags[IRQ_WOL])
		else $error("destination match flags not set");
	a_wake_hold:
	assert property (!wake_event_out_n && !wake_ctrl[WK_SELF_CLR] &&
		!wr_wake |=> !wake_event_out_n)
		else $error("wake output released without clear");
	a_first_indicator_pin_wake:
	assert property ($past(wake_ctrl[WK_FIRST_INDICATOR_PIN_SEL+:2]) == PIN_WAKE |->
		first_indicator_pin == $past(wake_event_out_n))
		else $error("first indicator not carrying wake output");
	a_soft_keep:
	assert property (soft_rst && !reg_wr && !wake_evt |=>
		$stable(wake_ctrl) && $stable(addr_low))
		else $error("wake registers lost on software reset");

endmodule

// file: host_watch.sv
// Host-side observer of the interrupt and wake outputs of pdw_core.
// Assumes both outputs are synchronous to clk_sys and active low.
module host_watch (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic interrupt_out_n,
	input wire logic wake_event_out_n,
	output logic [7:0] irq_falls,
	output logic [7:0] wake_falls
);
	timeunit 1ns;
	timeprecision 100ps;
	logic irq_q;
	logic wake_q;

	// ----------------------------------------
	// Edge counting
	// ----------------------------------------
	// The host listens on the dedicated wake output, so other interrupt
	// sources never disturb the wake count
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			irq_q <= 1'b1;
			wake_q <= 1'b1;
			irq_falls <= 8'h00;
			wake_falls <= 8'h00;
		end else begin
			irq_q <= interrupt_out_n;
			wake_q <= wake_event_out_n;
			if (wake_q && !wake_event_out_n) begin
				wake_falls <= wake_falls + 8'h01;
			end
			if (irq_q && !interrupt_out_n) begin
				irq_falls <= irq_falls + 8'h01;
			end
		end
	end
endmodule

// file: test_pdw_core.sv
// Self-checking bench for pdw_core with a host observer.
// Assumes short pulse timer units and the reduced interface strap high.
module test_pdw_core;
	timeunit 1ns;
	timeprecision 100ps;
	import pdw_pkg::*;
	localparam int TXU = 50;
	localparam int RXU = 20;
	localparam logic [47:0] ADDR = 48'h0A1B_2C3D_4E5F;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic soft_rst = 1'b0;
	logic [AW-1:0] reg_addr = 4'h0;
	logic [DW-1:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DW-1:0] reg_rdata;
	logic line_energy_pin = 1'b0;
	logic nlp_rx_pin = 1'b0;
	logic frame_done = 1'b0;
	logic frame_good = 1'b0;
	logic [47:0] frame_dest = 48'h0;
	logic frame_bcast = 1'b0;
	logic link_act_led = 1'b1;
	logic rxd2_data = 1'b0;
	logic reduced_if_strap = 1'b1;
	logic xcvr_power_down, xcvr_reset, tx_nlp_pulse, line_energy_present;
	logic interrupt_out_n, wake_event_out_n, rxd2_pin;
	logic first_indicator_pin, second_indicator_pin;
	logic [7:0] irq_falls, wake_falls;
	int error_cnt = 0;
	int total_checks = 0;
	int cyc = 0;

	always #2.5 clk_sys = ~clk_sys;

	pdw_core #(.TX_UNIT(TXU), .RX_UNIT(RXU)) dut_u (
		.clk_sys(clk_sys), .arst_n(arst_n), .soft_rst(soft_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.line_energy_pin(line_energy_pin), .nlp_rx_pin(nlp_rx_pin),
		.frame_done(frame_done), .frame_good(frame_good),
		.frame_dest(frame_dest), .frame_bcast(frame_bcast),
		.frame_magic(1'b0), .frame_pattern(1'b0),
		.link_act_led(link_act_led), .link_speed_led(1'b0),
		.rxd2_data(rxd2_data), .reduced_if_strap(reduced_if_strap),
		.regulator_off_strap(1'b0), .irq_pin_select_strap(1'b0),
		.xcvr_power_down(xcvr_power_down), .xcvr_reset(xcvr_reset),
		.tx_nlp_pulse(tx_nlp_pulse),
		.line_energy_present(line_energy_present),
		.interrupt_out_n(interrupt_out_n),
		.wake_event_out_n(wake_event_out_n),
		.first_indicator_pin(first_indicator_pin),
		.second_indicator_pin(second_indicator_pin), .rxd2_pin(rxd2_pin)
	);

	host_watch host_u (
		.clk_sys(clk_sys), .arst_n(arst_n),
		.interrupt_out_n(interrupt_out_n),
		.wake_event_out_n(wake_event_out_n),
		.irq_falls(irq_falls), .wake_falls(wake_falls)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic give_verdict();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp,
			input string what);
		total_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got,
				exp);
			error_cnt++;
		end
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic chk_reg(input logic [AW-1:0] a, input logic [DW-1:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e, "register");
	endtask

	task automatic frame(input logic [47:0] dest, input logic good);
		@(posedge clk_sys);
		frame_done <= 1'b1;
		frame_good <= good;
		frame_dest <= dest;
		@(posedge clk_sys);
		frame_done <= 1'b0;
		frame_good <= 1'b0;
	endtask

	task automatic nlp();
		@(posedge clk_sys);
		nlp_rx_pin <= 1'b1;
		repeat (4) @(posedge clk_sys);
		nlp_rx_pin <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk_reg(REG_CTRL, RST_ZERO);
		chk_reg(REG_MISC_CFG, RST_MISC);
		wr(4'hF, 16'hFFFF);
		chk_reg(4'hF, 16'h0000);
		wr(REG_STATUS, 16'hFFFF);
		chk_reg(REG_STATUS, 16'h0000);
		chk(DW'(interrupt_out_n), 16'h0001, "irq idle");
		chk(DW'(wake_event_out_n), 16'h0001, "wake idle");
	endtask

	task automatic t_power_down();
		int n;
		wr(REG_CTRL, 16'h0001);
		repeat (2) @(posedge clk_sys);
		#1 chk(DW'(xcvr_power_down), 16'h0001, "pd");
		wr(REG_CTRL, 16'h0000);
		n = 0;
		do begin
			@(posedge clk_sys);
			#1 n++;
		end while (xcvr_reset !== 1'b1 && n < 4);
		chk(DW'(n), 16'h0002, "pu reset start");
		n = 0;
		do begin
			@(posedge clk_sys);
			#1 n++;
		end while (xcvr_reset !== 1'b0 && n < 2100);
		chk(DW'(n), DW'(PU_RESET_CYC), "pu reset");
		chk(DW'(xcvr_power_down), 16'h0000, "pu");
	endtask

	task automatic t_dest();
		wr(REG_ADDR_LOW, ADDR[15:0]);
		wr(REG_ADDR_MID, ADDR[31:16]);
		wr(REG_ADDR_HIGH, ADDR[47:32]);
		wr(REG_WAKE_CTRL, 16'h1A02);
		frame(ADDR, 1'b1);
		repeat (4) @(posedge clk_sys);
		#1 chk(DW'(wake_event_out_n), 16'h0001, "disabled");
		wr(REG_WAKE_CTRL, 16'h1A01);
		wr(REG_IRQ_MASK, 16'h0100);
		frame(ADDR ^ 48'h1, 1'b1);
		frame(ADDR, 1'b0);
		repeat (4) @(posedge clk_sys);
		#1 chk(DW'(wake_event_out_n), 16'h0001, "no match");
		chk(DW'(first_indicator_pin), 16'h0001, "first_indicator_pin idle");
		chk(DW'(rxd2_pin), 16'h0001, "rxd2 idle");
		frame(ADDR, 1'b1);
		@(posedge clk_sys);
		#1 chk(DW'(wake_event_out_n), 16'h0000, "wake");
		@(posedge clk_sys);
		#1 chk(DW'(interrupt_out_n), 16'h0000, "irq");
		repeat (2) @(posedge clk_sys);
		#1 chk(DW'(first_indicator_pin), 16'h0000, "first_indicator_pin wake");
		chk(DW'(rxd2_pin), 16'h0000, "rxd2");
		chk(DW'(second_indicator_pin), 16'h0000, "second_indicator_pin irq");
		chk_reg(REG_WAKE_CTRL, 16'h1A11);
		chk_reg(REG_IRQ_FLAGS, 16'h0100);
		chk(DW'(wake_falls), 16'h0001, "host wake");
		chk(DW'(irq_falls), 16'h0001, "host irq");
		wr(REG_IRQ_FLAGS, 16'h0100);
		repeat (3) @(posedge clk_sys);
		#1 chk(DW'(interrupt_out_n), 16'h0001, "irq clr");
		chk(DW'(wake_event_out_n), 16'h0000, "wake held");
		wr(REG_WAKE_CTRL, 16'h1A11);
		repeat (3) @(posedge clk_sys);
		#1 chk(DW'(wake_event_out_n), 16'h0001, "wake clr");
	endtask

	task automatic t_self_clear();
		int n;
		wr(REG_WAKE_CTRL, 16'h0101);
		frame(ADDR, 1'b1);
		n = 0;
		do begin
			@(posedge clk_sys);
			#1 n++;
		end while (wake_event_out_n !== 1'b1 && n < 400);
		chk(DW'(n >= 200 && n <= 204), 16'h0001, "self clear");
		chk(DW'(rxd2_pin), 16'h0000, "rxd2 data");
		wr(REG_WAKE_CTRL, 16'h4111);
		wr(REG_IRQ_FLAGS, 16'h0180);
	endtask

	task automatic t_soft_reset();
		@(posedge clk_sys);
		soft_rst <= 1'b1;
		@(posedge clk_sys);
		soft_rst <= 1'b0;
		chk_reg(REG_WAKE_CTRL, 16'h4101);
		chk_reg(REG_ADDR_MID, ADDR[31:16]);
		chk_reg(REG_IRQ_MASK, 16'h0000);
	endtask

	task automatic t_energy_detect_power_down();
		int n;
		wr(REG_ENERGY_DETECT_POWER_DOWN_CFG, 16'h0001);
		repeat (8) @(posedge clk_sys);
		#1 chk(DW'(xcvr_power_down), 16'h0000, "energy_detect_power_down off");
		wr(REG_CTRL, 16'h0002);
		repeat (3) @(posedge clk_sys);
		#1 chk(DW'(xcvr_power_down), 16'h0001, "sleep");
		n = 0;
		while (tx_nlp_pulse !== 1'b1 && n < 200) begin
			@(posedge clk_sys);
			#1 n++;
		end
		n = 0;
		do begin
			@(posedge clk_sys);
			#1 n++;
		end while (tx_nlp_pulse !== 1'b1 && n < 200);
		chk(DW'(n), DW'(TXU + 1), "nlp gap");
		wr(REG_ENERGY_DETECT_POWER_DOWN_CFG, 16'h0000);
		n = 0;
		repeat (120) begin
			@(posedge clk_sys);
			#1 if (tx_nlp_pulse !== 1'b0) n++;
		end
		chk(DW'(n), 16'h0000, "nlp off");
		nlp();
		repeat (40) @(posedge clk_sys);
		chk_reg(REG_IRQ_FLAGS, 16'h0000);
		nlp();
		nlp();
		repeat (6) @(posedge clk_sys);
		chk_reg(REG_IRQ_FLAGS, 16'h0080);
		wr(REG_IRQ_FLAGS, 16'h0080);
		wr(REG_ENERGY_DETECT_POWER_DOWN_CFG, 16'h0008);
		nlp();
		repeat (6) @(posedge clk_sys);
		chk_reg(REG_IRQ_FLAGS, 16'h0080);
		wr(REG_IRQ_FLAGS, 16'h0080);
		wr(REG_IRQ_MASK, 16'h0080);
		line_energy_pin <= 1'b1;
		repeat (10) @(posedge clk_sys);
		#1 chk(DW'(line_energy_present), 16'h0001, "energy");
		chk(DW'(xcvr_power_down), 16'h0000, "awake");
		chk(DW'(interrupt_out_n), 16'h0000, "energy irq");
		wr(REG_IRQ_FLAGS, 16'h0080);
		wr(REG_CTRL, 16'h0000);
	endtask

	// ----------------------------------------
	// Sequence and hang guard
	// ----------------------------------------
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			$display("unexpected at %0t: timeout", $time);
			error_cnt++;
			give_verdict();
		end
	end

	initial begin
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_reset();
		t_power_down();
		t_dest();
		t_self_clear();
		t_soft_reset();
		t_energy_detect_power_down();
		give_verdict();
	end
endmodule
